// ===== core/fsg_cfg.svh
// Register map, field positions and timing counts of the frame sync generator
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH

// Register offsets
`define FSG_OFS_SYNC_CONTROL 8'h18
`define FSG_OFS_HIGH_UPPER 8'h19
`define FSG_OFS_HIGH_LOWER 8'h1a
`define FSG_OFS_LOW_UPPER 8'h1b
`define FSG_OFS_LOW_LOWER 8'h1c
`define FSG_OFS_PORT_SELECT 8'h4c
`define FSG_OFS_RATE_SELECT 8'h58
`define FSG_OFS_LINE_CTRL_A 8'h6e
`define FSG_OFS_LINE_CTRL_B 8'h6f

// Field positions in sync_control
`define FSG_BIT_GEN_ENABLE 0
`define FSG_BIT_DUTY_MODE 1
`define FSG_BIT_START_LEVEL 2
`define FSG_SRC_MSB 7
`define FSG_SRC_LSB 4
`define FSG_SRC_EXT_BIT 7

// Field positions in port_select
`define FSG_PSEL_WR_MSB 3
`define FSG_PSEL_RD_MSB 5
`define FSG_PSEL_RD_LSB 4

// Line select codes
`define FSG_LINE_SEL_HIGH 4'h1
`define FSG_LINE_SEL_SYNC 4'ha

// Reset values
`define FSG_RST_BYTE 8'h00
`define FSG_RST_PORT_SELECT 8'h01

// Timing: back-channel frame period at 2.5 Mbps, clock period
`define FSG_TICK_NS 12000
`define FSG_CLK_NS 20
`define FSG_TICK_CYC (`FSG_TICK_NS / `FSG_CLK_NS)

`endif

// ===== core/fsg_pkg.sv
// Types shared by the frame sync generator
package fsg_pkg;

  // Where the frame sync level currently comes from
  typedef enum logic [1:0] {
    FSG_SRC_NONE,
    FSG_SRC_EXT,
    FSG_SRC_INT
  } fsg_src_t;

  typedef logic [3:0] fsg_line_sel_t;

endpackage

// ===== core/fsg_frame_sync.sv
// Frame sync generator and back-channel line router of the camera hub
`timescale 1ns/100ps
`include "fsg_cfg.svh"

// Function
// - Sync can be routed to any back-channel line of any receive port.
// - Sync source is a local pin or the internal pulse generator.
// - All back-channel lines of all ports update on the same clock edge.
// - Source select 0x8 to 0xF picks local pins 0 to 7, generator off.
// - A line carries sync only when its line control selects sync.
// - Generator tick is one back-channel frame, 12 us, 30 bits of 400 ns.
// - Once enabled the generator runs continuously without further triggers.
// - Writing generator enable 1 in sync_control selects internal mode.
// - In internal mode source select is unused; every code gets the same frame tick.
// - Duty mode picks fixed 50/50 or separate high and low counts.
// - High and low durations are their counts times the tick period; a count of 0 gives one tick.
// - Generator timing derives from the reference clock only.
// - Source select zero uses the port 0 back-channel frame tick.
// - Start level bit sets the generator level when enabled; 0 is low.
// - High and low counts are 16 bits, upper and lower byte registers.
module fsg_frame_sync #(
  parameter int PORTS = 4,
  parameter int LINES = 4,
  parameter int GPIO_PINS = 8,
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Local general-purpose pins
  input wire logic [GPIO_PINS-1:0] gpio_i,
  // Back-channel lines, index port*LINES+line
  output logic [PORTS*LINES-1:0] backchannel_line_o,
  output logic frame_sync_pulse_o
);

  localparam int TICK_CYC = `FSG_TICK_CYC;
  localparam int TICK_W = $clog2(TICK_CYC);
  localparam int NLINE = PORTS * LINES;

  // Refuse parameter values that the fixed register decode cannot serve
  generate
    if (PORTS != 4 || LINES != 4 || GPIO_PINS != 8 || CNT_W != 16) begin : g_chk
      $error("fsg_frame_sync serves only 4 ports, 4 lines, 8 pins, 16-bit counts");
    end
  endgenerate

  // True when addr hits the given offset; the caller qualifies with the strobe
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = (addr == ofs);
  endfunction

  // Registers
  logic [7:0] sync_control;
  logic [CNT_W-1:0] sync_high_count;
  logic [CNT_W-1:0] sync_low_count;
  logic [7:0] port_select;
  logic [2:0] backchannel_rate_select [PORTS];
  fsg_pkg::fsg_line_sel_t line_sel [NLINE];

  logic gen_en;
  logic duty_mode;
  logic start_level;
  logic [3:0] src_sel;
  assign gen_en = sync_control[`FSG_BIT_GEN_ENABLE];
  assign duty_mode = sync_control[`FSG_BIT_DUTY_MODE];
  assign start_level = sync_control[`FSG_BIT_START_LEVEL];
  assign src_sel = sync_control[`FSG_SRC_MSB:`FSG_SRC_LSB];

  // Global registers, written byte by byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_control <= `FSG_RST_BYTE;
      sync_high_count <= {CNT_W{1'b0}};
      sync_low_count <= {CNT_W{1'b0}};
      port_select <= `FSG_RST_PORT_SELECT;
    end else if (reg_wr_i) begin
      if (wr_hit(reg_addr_i, `FSG_OFS_SYNC_CONTROL)) begin
        sync_control <= reg_wdata_i;
      end else if (wr_hit(reg_addr_i, `FSG_OFS_HIGH_UPPER)) begin
        sync_high_count[15:8] <= reg_wdata_i;
      end else if (wr_hit(reg_addr_i, `FSG_OFS_HIGH_LOWER)) begin
        sync_high_count[7:0] <= reg_wdata_i;
      end else if (wr_hit(reg_addr_i, `FSG_OFS_LOW_UPPER)) begin
        sync_low_count[15:8] <= reg_wdata_i;
      end else if (wr_hit(reg_addr_i, `FSG_OFS_LOW_LOWER)) begin
        sync_low_count[7:0] <= reg_wdata_i;
      end else if (wr_hit(reg_addr_i, `FSG_OFS_PORT_SELECT)) begin
        port_select <= reg_wdata_i;
      end
    end
  end

  // Per-port registers; one write may reach several ports at once
  genvar gp;
  genvar gl;
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_port
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          backchannel_rate_select[gp] <= 3'h0;
        end else if (reg_wr_i && port_select[gp] &&
                     wr_hit(reg_addr_i, `FSG_OFS_RATE_SELECT)) begin
          backchannel_rate_select[gp] <= reg_wdata_i[2:0];
        end
      end
      for (gl = 0; gl < LINES; gl++) begin : g_line
        localparam logic [7:0] OFS = (gl < 2) ? `FSG_OFS_LINE_CTRL_A : `FSG_OFS_LINE_CTRL_B;
        localparam int NIB = (gl % 2) * 4;
        always_ff @(posedge clk_sys_i) begin
          if (rst_i) begin
            line_sel[gp*LINES+gl] <= 4'h0;
          end else if (reg_wr_i && port_select[gp] && wr_hit(reg_addr_i, OFS)) begin
            line_sel[gp*LINES+gl] <= reg_wdata_i[NIB+:4];
          end
        end
      end
    end
  endgenerate

  // Read data, held until the next read
  logic [1:0] rd_port;
  assign rd_port = port_select[`FSG_PSEL_RD_MSB:`FSG_PSEL_RD_LSB];
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `FSG_OFS_SYNC_CONTROL) begin
        reg_rdata_o <= sync_control;
      end else if (reg_addr_i == `FSG_OFS_HIGH_UPPER) begin
        reg_rdata_o <= sync_high_count[15:8];
      end else if (reg_addr_i == `FSG_OFS_HIGH_LOWER) begin
        reg_rdata_o <= sync_high_count[7:0];
      end else if (reg_addr_i == `FSG_OFS_LOW_UPPER) begin
        reg_rdata_o <= sync_low_count[15:8];
      end else if (reg_addr_i == `FSG_OFS_LOW_LOWER) begin
        reg_rdata_o <= sync_low_count[7:0];
      end else if (reg_addr_i == `FSG_OFS_PORT_SELECT) begin
        reg_rdata_o <= port_select;
      end else if (reg_addr_i == `FSG_OFS_RATE_SELECT) begin
        reg_rdata_o <= {5'h00, backchannel_rate_select[rd_port]};
      end else if (reg_addr_i == `FSG_OFS_LINE_CTRL_A) begin
        reg_rdata_o <= {line_sel[rd_port*LINES+1], line_sel[rd_port*LINES]};
      end else if (reg_addr_i == `FSG_OFS_LINE_CTRL_B) begin
        reg_rdata_o <= {line_sel[rd_port*LINES+3], line_sel[rd_port*LINES+2]};
      end else begin
        reg_rdata_o <= 8'h00; // Unmapped offsets read zero
      end
    end
  end

  // Back-channel frame tick; free running so every source shares one phase
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
    end else if (tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end
  // Every source code counts the same frame period; code zero is port 0
  assign tick = (tick_cnt == TICK_W'(TICK_CYC - 1));

  // Source decision: enable wins, then pin select, else idle low
  fsg_pkg::fsg_src_t src;
  always_comb begin
    if (gen_en) begin
      src = fsg_pkg::FSG_SRC_INT;
    end else if (src_sel[3]) begin
      src = fsg_pkg::FSG_SRC_EXT;
    end else begin
      src = fsg_pkg::FSG_SRC_NONE;
    end
  end

  // Reload count for a level; 50/50 uses the high count for both halves
  logic [CNT_W-1:0] high_len;
  logic [CNT_W-1:0] low_len;
  assign high_len = sync_high_count;
  assign low_len = duty_mode ? sync_high_count : sync_low_count;

  // Enable seen on the previous edge; its absence marks the first enabled cycle
  logic gen_was_enabled;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gen_was_enabled <= 1'b0;
    end else begin
      gen_was_enabled <= gen_en;
    end
  end

  // Generator level and remaining ticks; armed while off, reloaded at enable
  logic gen_level;
  logic [CNT_W-1:0] gen_cnt;
  logic wrap;
  assign wrap = tick && (gen_cnt <= 16'h0001);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      gen_level <= 1'b0;
      gen_cnt <= {CNT_W{1'b0}};
    end else if (!gen_en) begin
      gen_level <= start_level;
      gen_cnt <= start_level ? high_len : low_len;
    end else if (!gen_was_enabled) begin
      // Start level written together with the enable must still be honoured
      gen_level <= start_level;
      gen_cnt <= start_level ? high_len : low_len;
    end else if (wrap) begin
      gen_level <= !gen_level;
      gen_cnt <= gen_level ? low_len : high_len;
    end else if (tick) begin
      gen_cnt <= gen_cnt - 1'b1;
    end
  end

  // Selected sync level, registered once for all lines
  logic next_frame_sync;
  always_comb begin
    case (src)
      fsg_pkg::FSG_SRC_INT: next_frame_sync = gen_level;
      fsg_pkg::FSG_SRC_EXT: next_frame_sync = gpio_i[src_sel[2:0]];
      default: next_frame_sync = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_sync_pulse_o <= 1'b0;
    end else begin
      frame_sync_pulse_o <= next_frame_sync;
    end
  end

  // Line drivers; all share one edge so skew between ports stays at zero
  generate
    for (gp = 0; gp < NLINE; gp++) begin : g_out
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          backchannel_line_o[gp] <= 1'b0;
        end else if (line_sel[gp] == `FSG_LINE_SEL_SYNC) begin
          backchannel_line_o[gp] <= frame_sync_pulse_o;
        end else begin
          backchannel_line_o[gp] <= (line_sel[gp] == `FSG_LINE_SEL_HIGH);
        end
      end
    end
  endgenerate

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_tick_wrap;
    gen_en && gen_was_enabled && wrap;
  endsequence
  sequence s_tick_hold;
    gen_en && gen_was_enabled && tick && !wrap;
  endsequence

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick repeated early");

  property p_tick_bound;
    tick_cnt < TICK_W'(TICK_CYC);
  endproperty
  a_tick_bound: assert property (p_tick_bound) else $error("tick count out of range");

  property p_ext_path;
    (src == fsg_pkg::FSG_SRC_EXT) |=> frame_sync_pulse_o == $past(gpio_i[src_sel[2:0]]);
  endproperty
  a_ext_path: assert property (p_ext_path) else $error("pin not forwarded");

  property p_int_path;
    gen_en |=> frame_sync_pulse_o == $past(gen_level);
  endproperty
  a_int_path: assert property (p_int_path) else $error("generator not forwarded");

  property p_idle_low;
    (src == fsg_pkg::FSG_SRC_NONE) |=> !frame_sync_pulse_o;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("sync not low when idle");

  property p_start;
    !gen_en |=> gen_level == $past(start_level);
  endproperty
  a_start: assert property (p_start) else $error("start level wrong");

  property p_arm;
    gen_en && !gen_was_enabled |=> gen_level == $past(start_level);
  endproperty
  a_arm: assert property (p_arm) else $error("start level not taken at enable");

  property p_toggle;
    s_tick_wrap |=> gen_level != $past(gen_level) &&
      gen_cnt == ($past(gen_level) ? $past(low_len) : $past(high_len));
  endproperty
  a_toggle: assert property (p_toggle) else $error("bad level change");

  property p_hold;
    s_tick_hold |=> gen_level == $past(gen_level) && gen_cnt == $past(gen_cnt) - 16'h0001;
  endproperty
  a_hold: assert property (p_hold) else $error("bad tick count");

  property p_no_tick_stay;
    gen_en && gen_was_enabled && !tick |=>
      gen_level == $past(gen_level) && gen_cnt == $past(gen_cnt);
  endproperty
  a_no_tick_stay: assert property (p_no_tick_stay) else $error("change off tick");

  property p_line_sync;
    line_sel[0] == `FSG_LINE_SEL_SYNC && $stable(line_sel[0]) |=>
      backchannel_line_o[0] == $past(frame_sync_pulse_o);
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("line 0 lost sync");

  property p_line_same;
    line_sel[0] == `FSG_LINE_SEL_SYNC && line_sel[NLINE-1] == `FSG_LINE_SEL_SYNC |=>
      backchannel_line_o[0] == backchannel_line_o[NLINE-1];
  endproperty
  a_line_same: assert property (p_line_same) else $error("ports skewed");

endmodule

// ===== sim/fsg_serializer_model.sv
// Serializer-side model timing the sync seen on the back-channel lines
`timescale 1ns/100ps
module fsg_serializer_model (
  // Clock
  input wire logic clk_sys_i,
  // Back-channel lines from the hub
  input wire logic [15:0] backchannel_line_i,
  // Measured shape of port 0 line 0, and skew of line 0 against ports 1 and 2
  output logic [31:0] high_len_o = 32'h0,
  output logic [31:0] low_len_o = 32'h0,
  output logic [31:0] edges_o = 32'h0,
  output logic skew_err_o = 1'b0
);
  logic [31:0] run = 32'h0;
  logic last = 1'b0;

  // Time each level; the first one after a setup change is partial
  always @(posedge clk_sys_i) begin
    if (backchannel_line_i[0] !== last) begin
      if (last) begin
        high_len_o <= run;
      end else begin
        low_len_o <= run;
      end
      edges_o <= edges_o + 1;
      run <= 32'h1;
    end else begin
      run <= run + 1;
    end
    last <= backchannel_line_i[0];
    // Ports 0 to 2 share one line setup, so their sync must land together
    if (backchannel_line_i[0] !== backchannel_line_i[4] ||
        backchannel_line_i[0] !== backchannel_line_i[8]) begin
      skew_err_o <= 1'b1;
    end
  end
endmodule

// ===== sim/fsg_frame_sync_tb.sv
// Self-checking bench for the frame sync generator
`timescale 1ns/100ps
`include "fsg_cfg.svh"
module fsg_frame_sync_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i;
  logic [7:0] reg_addr_i;
  logic reg_wr_i;
  logic [7:0] reg_wdata_i;
  logic reg_rd_i;
  logic [7:0] reg_rdata_o;
  logic [7:0] gpio_i;
  logic [15:0] backchannel_line_o;
  logic frame_sync_pulse_o;
  logic [31:0] high_len;
  logic [31:0] low_len;
  logic [31:0] edges;
  logic skew_err;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  fsg_frame_sync u_fsg_frame_sync (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .gpio_i(gpio_i), .backchannel_line_o(backchannel_line_o),
    .frame_sync_pulse_o(frame_sync_pulse_o)
  );
  fsg_serializer_model u_fsg_serializer_model (
    .clk_sys_i(clk_sys_i), .backchannel_line_i(backchannel_line_o), .high_len_o(high_len),
    .low_len_o(low_len), .edges_o(edges), .skew_err_o(skew_err)
  );

  // Clock and hang guard; the run needs well under 30k cycles
  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Register strobes are launched at the falling edge and held over one rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    @(negedge clk_sys_i);
    chk_reg(what, exp, reg_rdata_o);
  endtask

  task automatic wait_edges(input int n);
    int start;
    int k;
    start = edges;
    k = 0;
    while (edges - start < n && k < 8000) begin
      @(negedge clk_sys_i);
      k++;
    end
    chk_val("edge wait", 32'h1, {31'h0, k < 8000});
  endtask

  // Ports 0..2 carry sync on lines 0..2, port 3 only on line 2; line 3 is tied high
  function automatic logic [15:0] lines_exp(input logic s);
    return {1'b1, s, 2'b00, {3{1'b1, s, s, s}}};
  endfunction

  task automatic t_reset();
    rd_chk("sync_control", `FSG_OFS_SYNC_CONTROL, 8'h00);
    rd_chk("high upper", `FSG_OFS_HIGH_UPPER, 8'h00);
    rd_chk("port_select", `FSG_OFS_PORT_SELECT, 8'h01);
    wr(`FSG_OFS_LOW_UPPER, 8'ha5);
    rd_chk("low upper", `FSG_OFS_LOW_UPPER, 8'ha5);
    wr(8'h30, 8'hff);
    rd_chk("unmapped", 8'h30, 8'h00);
  endtask

  task automatic t_external();
    wr(`FSG_OFS_PORT_SELECT, 8'h0f);
    wr(`FSG_OFS_LINE_CTRL_A, 8'haa);
    wr(`FSG_OFS_LINE_CTRL_B, 8'h1a);
    wr(`FSG_OFS_PORT_SELECT, 8'h08);
    wr(`FSG_OFS_LINE_CTRL_A, 8'h00);
    wr(`FSG_OFS_RATE_SELECT, 8'h05);
    wr(`FSG_OFS_PORT_SELECT, 8'h38);
    rd_chk("line a port 3", `FSG_OFS_LINE_CTRL_A, 8'h00);
    rd_chk("line b port 3", `FSG_OFS_LINE_CTRL_B, 8'h1a);
    rd_chk("rate port 3", `FSG_OFS_RATE_SELECT, 8'h05);
    wr(`FSG_OFS_PORT_SELECT, 8'h00);
    rd_chk("line a port 0", `FSG_OFS_LINE_CTRL_A, 8'haa);
    rd_chk("rate port 0", `FSG_OFS_RATE_SELECT, 8'h00);
    for (int n = 0; n < 8; n++) begin
      wr(`FSG_OFS_SYNC_CONTROL, {4'h8 + 4'(n), 4'h0});
      for (int v = 0; v < 2; v++) begin
        gpio_i = v[0] ? 8'h01 << n : ~(8'h01 << n);
        repeat (3) @(negedge clk_sys_i);
        chk_val("sync", {31'h0, v[0]}, {31'h0, frame_sync_pulse_o});
        chk_val("lines", {16'h0, lines_exp(v[0])}, {16'h0, backchannel_line_o});
      end
    end
    gpio_i = 8'h00;
    wr(`FSG_OFS_SYNC_CONTROL, 8'h00);
  endtask

  // The first level after enable may be cut short by the tick phase
  task automatic t_internal();
    wr(`FSG_OFS_HIGH_UPPER, 8'h00);
    wr(`FSG_OFS_HIGH_LOWER, 8'h02);
    wr(`FSG_OFS_LOW_UPPER, 8'h00);
    wr(`FSG_OFS_LOW_LOWER, 8'h03);
    wr(`FSG_OFS_SYNC_CONTROL, 8'h01);
    for (int r = 0; r < 2; r++) begin
      wait_edges(3);
      chk_val("high time", 32'd2 * `FSG_TICK_CYC, high_len);
      chk_val("low time", 32'd3 * `FSG_TICK_CYC, low_len);
    end
  endtask

  task automatic t_half();
    wr(`FSG_OFS_SYNC_CONTROL, 8'h00);
    wr(`FSG_OFS_SYNC_CONTROL, 8'h07);
    repeat (3) @(negedge clk_sys_i);
    chk_val("start", 32'h1, {31'h0, frame_sync_pulse_o});
    chk_val("lines", {16'h0, lines_exp(1'b1)}, {16'h0, backchannel_line_o});
    wait_edges(4);
    chk_val("half high", 32'd2 * `FSG_TICK_CYC, high_len);
    chk_val("half low", 32'd2 * `FSG_TICK_CYC, low_len);
  endtask

  // Main sequence
  initial begin
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
    gpio_i = 8'h00;
    repeat (12) @(negedge clk_sys_i);
    rst_i = 1'b0;
    t_reset();
    t_external();
    t_internal();
    t_half();
    chk_val("skew", 32'h0, {31'h0, skew_err});
    stop_test();
  end
endmodule
